// File: common/flash_cmd_defs.svh
// constants of the serial flash command interpreter
`ifndef FLASH_CMD_DEFS_SVH
`define FLASH_CMD_DEFS_SVH

`define BYTE_BITS        8
`define ADDR_W           19
`define FIFO_DEPTH       8

`define OP_READ          8'h03
`define OP_FAST_READ     8'h0B
`define OP_SECTOR_ERASE  8'h20
`define OP_BLOCK_ERASE   8'h52
`define OP_CHIP_ERASE    8'h60
`define OP_BYTE_PROG     8'h02
`define OP_AUTO_PROG     8'hAF
`define OP_STATUS_READ   8'h05
`define OP_STATUS_ARM    8'h50
`define OP_STATUS_WRITE  8'h01
`define OP_LATCH_SET     8'h06
`define OP_LATCH_CLEAR   8'h04
`define OP_ID_READ_A     8'h90
`define OP_ID_READ_B     8'hAB

`define TOP_ADDR_LARGE   19'h7FFFF
`define TOP_ADDR_SMALL   19'h3FFFF
`define SECTOR_LSB       12
`define BLOCK_LSB        15

// reset values of the status bits
`define PROTECT_RST      2'h3
`define PROTECT_LOCK_RST 1'h0

// identification bytes: values are arbitrary
`define MAKER_CODE       8'h5A
`define PART_CODE_SMALL  8'h6B
`define PART_CODE_LARGE  8'h6C

`endif

// File: common/flash_cmd_pkg.sv
// types shared by the serial flash command interpreter
package flash_cmd_pkg;
  `include "flash_cmd_defs.svh"

  typedef enum logic [2:0] {
    ST_OPCODE = 3'h0,
    ST_ADDR   = 3'h1,
    ST_DUMMY  = 3'h3,
    ST_OUT    = 3'h2,
    ST_DATA   = 3'h6,
    ST_DONE   = 3'h7
  } state_t;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [7:0]         data;
  } prog_word_t;

  typedef enum logic [1:0] {
    ER_SECTOR = 2'h0,
    ER_BLOCK  = 2'h1,
    ER_CHIP   = 2'h2
  } erase_kind_t;

  typedef struct packed {
    logic               valid;
    erase_kind_t        kind;
    logic [`ADDR_W-1:0] addr;
  } erase_req_t;
endpackage : flash_cmd_pkg

// File: design/prog_fifo.sv
// program-word fifo with registered output stage
`timescale 1ns/100ps
module prog_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  // depth must be a power of two so that pointers wrap by themselves
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic             push;
  logic             pop;

  assign in_ready_o = (count_reg != CW'(DEPTH));
  assign push       = in_valid_i & in_ready_o;
  assign pop        = (count_reg != '0) & (~out_valid_o | out_ready_i);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + PW'(1);
      end
      if (push & ~pop) begin
        count_reg <= count_reg + CW'(1);
      end else if (pop & ~push) begin
        count_reg <= count_reg - CW'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem_reg[rd_ptr_reg];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule : prog_fifo

// File: design/flash_cmd.sv
// serial flash instruction decoder and read/program/id sequencer
`timescale 1ns/100ps
`include "flash_cmd_defs.svh"
module flash_cmd #(
  parameter bit LARGE_DENSITY = 1'b1
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      sck_i,
  input  wire logic                      cs_n_i,
  input  wire logic                      si_i,
  output logic                           so_o,
  output logic                           so_oe_o,
  output logic                           rd_req_o,
  output logic [`ADDR_W-1:0]             rd_addr_o,
  input  wire logic [7:0]                rd_data_i,
  input  wire logic                      array_busy_i,
  output flash_cmd_pkg::prog_word_t      prog_o,
  output logic                           prog_valid_o,
  input  wire logic                      prog_ready_i,
  output flash_cmd_pkg::erase_req_t      erase_o,
  output logic [1:0]                     protect_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [`ADDR_W-1:0] top_addr();
    return LARGE_DENSITY ? `TOP_ADDR_LARGE : `TOP_ADDR_SMALL;
  endfunction : top_addr

  function automatic logic [`ADDR_W-1:0] mask_addr(input logic [23:0] a);
    return {a[18] & LARGE_DENSITY, a[17:0]};
  endfunction : mask_addr

  function automatic logic [`ADDR_W-1:0] next_addr(input logic [`ADDR_W-1:0] a);
    return (a == top_addr()) ? '0 : a + `ADDR_W'(1);
  endfunction : next_addr

  function automatic logic is_prog(input logic [7:0] op);
    return (op == `OP_BYTE_PROG) || (op == `OP_AUTO_PROG);
  endfunction : is_prog

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: bit 2 sck, bit 1 select, bit 0 serial in

  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic [2:0] pin_s3_reg;
  logic [2:0] pin_f_reg;
  logic       sck_prev_reg;
  logic       cs_prev_reg;
  logic       sck_f;
  logic       cs_f;
  logic       si_f;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_rise;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_reg <= 3'h2;
      pin_s2_reg <= 3'h2;
      pin_s3_reg <= 3'h2;
      pin_f_reg  <= 3'h2;
    end else begin
      pin_s1_reg <= {sck_i, cs_n_i, si_i};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      for (int i = 0; i < 3; i++) begin
        // a level counts only once two stages agree
        if (pin_s2_reg[i] == pin_s3_reg[i]) begin
          pin_f_reg[i] <= pin_s3_reg[i];
        end
      end
    end
  end

  assign sck_f = pin_f_reg[2];
  assign cs_f  = pin_f_reg[1];
  assign si_f  = pin_f_reg[0];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg  <= 1'b1;
    end else begin
      sck_prev_reg <= sck_f;
      cs_prev_reg  <= cs_f;
    end
  end

  assign sck_rise = sck_f & ~sck_prev_reg & ~cs_f;
  assign sck_fall = ~sck_f & sck_prev_reg & ~cs_f;
  assign cs_rise  = cs_f & ~cs_prev_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // bit assembly

  logic [7:0] rx_reg;
  logic [2:0] bit_cnt_reg;
  logic       byte_done;
  logic [7:0] byte_val;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_reg      <= 8'h00;
      bit_cnt_reg <= 3'h0;
    end else if (cs_f) begin
      bit_cnt_reg <= 3'h0;
    end else if (sck_rise) begin
      rx_reg      <= byte_val;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  assign byte_done = sck_rise & (bit_cnt_reg == 3'h7);
  assign byte_val  = {rx_reg[6:0], si_f};

  ////////////////////////////////////////////////////////////////////////////////
  // instruction sequencer

  flash_cmd_pkg::state_t    state_reg;
  logic [7:0]               op_reg;
  logic [15:0]              addr_hi_reg;
  logic [1:0]               addr_cnt_reg;
  logic [`ADDR_W-1:0]       ptr_reg;
  logic                     id_sel_reg;
  logic                     rd_req_reg;
  logic                     rd_wait_reg;
  logic [7:0]               mem_byte_reg;
  logic                     pend_valid_reg;
  logic [7:0]               pend_op_reg;
  logic [`ADDR_W-1:0]       pend_addr_reg;
  logic [7:0]               pend_data_reg;
  logic                     status_ok_reg;
  logic                     latch_reg;
  logic                     aai_reg;
  logic [`ADDR_W-1:0]       aai_addr_reg;
  logic                     arm_reg;
  logic [1:0]               protect_reg;
  logic                     lock_reg;
  logic [`ADDR_W-1:0]       full_addr;
  logic                     opcode_done;
  logic                     push_req;
  logic                     exec_fire;
  logic                     fifo_in_ready;
  flash_cmd_pkg::prog_word_t fifo_in;

  assign full_addr   = mask_addr({addr_hi_reg, byte_val});
  assign opcode_done = byte_done & (state_reg == flash_cmd_pkg::ST_OPCODE);
  assign push_req    = pend_valid_reg & is_prog(pend_op_reg) & latch_reg;
  // execution of a program word waits while the program fifo is full
  assign exec_fire   = cs_f & ~cs_rise & pend_valid_reg & (~push_req | fifo_in_ready);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg      <= flash_cmd_pkg::ST_OPCODE;
      op_reg         <= 8'h00;
      addr_hi_reg    <= 16'h0000;
      addr_cnt_reg   <= 2'h0;
      ptr_reg        <= '0;
      id_sel_reg     <= 1'b0;
      rd_req_reg     <= 1'b0;
      pend_valid_reg <= 1'b0;
      pend_op_reg    <= 8'h00;
      pend_addr_reg  <= '0;
      pend_data_reg  <= 8'h00;
      status_ok_reg  <= 1'b0;
    end else begin
      rd_req_reg <= 1'b0;
      if (cs_rise && bit_cnt_reg != 3'h0) begin
        pend_valid_reg <= 1'b0;
      end else if (exec_fire) begin
        pend_valid_reg <= 1'b0;
      end
      if (cs_f) begin
        state_reg <= flash_cmd_pkg::ST_OPCODE;
      end else if (byte_done) begin
        case (state_reg)
          flash_cmd_pkg::ST_OPCODE: begin
            op_reg        <= byte_val;
            addr_cnt_reg  <= 2'h0;
            status_ok_reg <= arm_reg & (byte_val == `OP_STATUS_WRITE);
            if (pend_valid_reg && byte_val != `OP_STATUS_READ) begin
              state_reg <= flash_cmd_pkg::ST_DONE;
            end else begin
              case (byte_val)
                `OP_READ, `OP_FAST_READ, `OP_SECTOR_ERASE, `OP_BLOCK_ERASE,
                `OP_BYTE_PROG, `OP_ID_READ_A, `OP_ID_READ_B: begin
                  state_reg <= flash_cmd_pkg::ST_ADDR;
                end
                `OP_AUTO_PROG: begin
                  pend_addr_reg <= aai_addr_reg;
                  state_reg <= aai_reg ? flash_cmd_pkg::ST_DATA : flash_cmd_pkg::ST_ADDR;
                end
                `OP_STATUS_READ: begin
                  state_reg <= flash_cmd_pkg::ST_OUT;
                end
                `OP_STATUS_WRITE: begin
                  state_reg <= flash_cmd_pkg::ST_DATA;
                end
                default: begin
                  pend_op_reg    <= byte_val;
                  pend_valid_reg <= 1'b1;
                  state_reg      <= flash_cmd_pkg::ST_DONE;
                end
              endcase
            end
          end
          flash_cmd_pkg::ST_ADDR: begin
            addr_hi_reg  <= {addr_hi_reg[7:0], byte_val};
            addr_cnt_reg <= addr_cnt_reg + 2'h1;
            if (addr_cnt_reg == 2'h2) begin
              pend_addr_reg <= full_addr;
              ptr_reg       <= full_addr;
              id_sel_reg    <= byte_val[0];
              case (op_reg)
                `OP_READ: begin
                  rd_req_reg <= 1'b1;
                  ptr_reg    <= next_addr(full_addr);
                  state_reg  <= flash_cmd_pkg::ST_OUT;
                end
                `OP_FAST_READ: begin
                  state_reg <= flash_cmd_pkg::ST_DUMMY;
                end
                `OP_ID_READ_A, `OP_ID_READ_B: begin
                  state_reg <= flash_cmd_pkg::ST_OUT;
                end
                `OP_BYTE_PROG, `OP_AUTO_PROG: begin
                  state_reg <= flash_cmd_pkg::ST_DATA;
                end
                default: begin
                  pend_op_reg    <= op_reg;
                  pend_valid_reg <= 1'b1;
                  state_reg      <= flash_cmd_pkg::ST_DONE;
                end
              endcase
            end
          end
          flash_cmd_pkg::ST_DUMMY: begin
            // dummy bits are shifted in and dropped
            rd_req_reg <= 1'b1;
            ptr_reg    <= next_addr(ptr_reg);
            state_reg  <= flash_cmd_pkg::ST_OUT;
          end
          flash_cmd_pkg::ST_DATA: begin
            pend_op_reg    <= op_reg;
            pend_data_reg  <= byte_val;
            pend_valid_reg <= 1'b1;
            state_reg      <= flash_cmd_pkg::ST_DONE;
          end
          flash_cmd_pkg::ST_OUT: begin
            if (op_reg == `OP_READ || op_reg == `OP_FAST_READ) begin
              rd_req_reg <= 1'b1;
              ptr_reg    <= next_addr(ptr_reg);
            end
            id_sel_reg <= ~id_sel_reg;
          end
          default: begin
            state_reg <= flash_cmd_pkg::ST_DONE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // array read port and serial output

  logic [7:0] tx_reg;
  logic [7:0] tx_src;
  logic [7:0] status_byte;

  assign status_byte = {lock_reg, aai_reg, 2'h0, protect_reg, latch_reg,
                        array_busy_i | pend_valid_reg};

  always_comb begin
    case (op_reg)
      `OP_STATUS_READ: tx_src = status_byte;
      `OP_ID_READ_A, `OP_ID_READ_B: begin
        tx_src = id_sel_reg ? (LARGE_DENSITY ? `PART_CODE_LARGE : `PART_CODE_SMALL)
                            : `MAKER_CODE;
      end
      default: tx_src = mem_byte_reg;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_req_o     <= 1'b0;
      rd_addr_o    <= '0;
      rd_wait_reg  <= 1'b0;
      mem_byte_reg <= 8'h00;
    end else begin
      rd_req_o    <= rd_req_reg;
      rd_wait_reg <= rd_req_o;
      if (rd_req_reg) begin
        // pointer already stands one past the byte being fetched
        rd_addr_o <= (ptr_reg == '0) ? top_addr() : ptr_reg - `ADDR_W'(1);
      end
      if (rd_wait_reg) begin
        mem_byte_reg <= rd_data_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      so_o    <= 1'b0;
      so_oe_o <= 1'b0;
      tx_reg  <= 8'h00;
    end else begin
      so_oe_o <= ~cs_f & (state_reg == flash_cmd_pkg::ST_OUT);
      if (sck_fall && state_reg == flash_cmd_pkg::ST_OUT) begin
        if (bit_cnt_reg == 3'h0) begin
          so_o   <= tx_src[7];
          tx_reg <= {tx_src[6:0], 1'b0};
        end else begin
          so_o   <= tx_reg[7];
          tx_reg <= {tx_reg[6:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // execution of completed instructions once select is high

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_reg    <= 1'b0;
      aai_reg      <= 1'b0;
      aai_addr_reg <= '0;
      arm_reg      <= 1'b0;
      protect_reg  <= `PROTECT_RST;
      lock_reg     <= `PROTECT_LOCK_RST;
      erase_o      <= '0;
    end else begin
      erase_o.valid <= 1'b0;
      if (opcode_done) begin
        arm_reg <= 1'b0;
      end
      if (exec_fire) begin
        case (pend_op_reg)
          `OP_LATCH_SET: latch_reg <= 1'b1;
          `OP_LATCH_CLEAR: begin
            latch_reg <= 1'b0;
            aai_reg   <= 1'b0;
          end
          `OP_STATUS_ARM: arm_reg <= 1'b1;
          `OP_STATUS_WRITE: begin
            if (status_ok_reg && !lock_reg) begin
              protect_reg <= pend_data_reg[3:2];
              lock_reg    <= pend_data_reg[7];
            end
          end
          `OP_BYTE_PROG: latch_reg <= 1'b0;
          `OP_AUTO_PROG: begin
            if (latch_reg) begin
              aai_reg      <= (pend_addr_reg != top_addr());
              latch_reg    <= (pend_addr_reg != top_addr());
              aai_addr_reg <= pend_addr_reg + `ADDR_W'(1);
            end
          end
          `OP_SECTOR_ERASE, `OP_BLOCK_ERASE: begin
            if (latch_reg) begin
              latch_reg     <= 1'b0;
              erase_o.valid <= 1'b1;
              if (pend_op_reg == `OP_SECTOR_ERASE) begin
                erase_o.kind <= flash_cmd_pkg::ER_SECTOR;
                erase_o.addr <= {pend_addr_reg[`ADDR_W-1:`SECTOR_LSB],
                                 `SECTOR_LSB'(0)};
              end else begin
                erase_o.kind <= flash_cmd_pkg::ER_BLOCK;
                erase_o.addr <= {pend_addr_reg[`ADDR_W-1:`BLOCK_LSB],
                                 `BLOCK_LSB'(0)};
              end
            end
          end
          `OP_CHIP_ERASE: begin
            if (latch_reg && protect_reg == 2'h0) begin
              latch_reg     <= 1'b0;
              erase_o.valid <= 1'b1;
              erase_o.kind  <= flash_cmd_pkg::ER_CHIP;
              erase_o.addr  <= '0;
            end
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // program fifo toward the array

  assign fifo_in = '{addr: pend_addr_reg, data: pend_data_reg};

  prog_fifo #(
    .WIDTH ($bits(flash_cmd_pkg::prog_word_t)),
    .DEPTH (`FIFO_DEPTH)
  ) u_prog_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (exec_fire & push_req),
    .in_data_i   (fifo_in),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (prog_valid_o),
    .out_data_o  (prog_o),
    .out_ready_i (prog_ready_i)
  );

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      protect_o <= `PROTECT_RST;
    end else begin
      protect_o <= protect_reg;
    end
  end
endmodule : flash_cmd

// File: verif/flash_cmd_props.sv
// port checker for the flash command interpreter
`timescale 1ns/100ps
`include "flash_cmd_defs.svh"
module flash_cmd_props #(
  parameter bit LARGE_DENSITY = 1'b1
) (
  input wire logic                      clk_i,
  input wire logic                      rst_n_i,
  input wire logic                      cs_n_i,
  input wire logic                      so_oe_o,
  input wire logic                      rd_req_o,
  input wire logic [`ADDR_W-1:0]        rd_addr_o,
  input wire flash_cmd_pkg::erase_req_t erase_o,
  input wire flash_cmd_pkg::prog_word_t prog_o,
  input wire logic                      prog_valid_o,
  input wire logic                      prog_ready_i,
  input wire logic [1:0]                protect_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  property p_oe_off; cs_n_i [*6] |-> !so_oe_o; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output enable with select high");
  property p_oe_sel; $rose(so_oe_o) |-> !cs_n_i; endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("output enabled outside a frame");
  property p_rd_top;
    rd_req_o |-> rd_addr_o <= (LARGE_DENSITY ? `TOP_ADDR_LARGE : `TOP_ADDR_SMALL);
  endproperty
  a_rd_top: assert property (p_rd_top) else $error("read address above top");
  property p_rd_pulse; rd_req_o |=> !rd_req_o; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read request longer than a cycle");
  property p_sector;
    erase_o.valid && erase_o.kind == flash_cmd_pkg::ER_SECTOR |-> erase_o.addr[11:0] == 12'h000;
  endproperty
  a_sector: assert property (p_sector) else $error("sector erase address not aligned");
  property p_block;
    erase_o.valid && erase_o.kind == flash_cmd_pkg::ER_BLOCK |-> erase_o.addr[14:0] == 15'h0000;
  endproperty
  a_block: assert property (p_block) else $error("block erase address not aligned");
  property p_chip;
    erase_o.valid && erase_o.kind == flash_cmd_pkg::ER_CHIP |-> protect_o == 2'h0;
  endproperty
  a_chip: assert property (p_chip) else $error("chip erase while protected");
  property p_hold; prog_valid_o && !prog_ready_i |=> prog_valid_o && $stable(prog_o); endproperty
  a_hold: assert property (p_hold) else $error("program word dropped while stalled");
endmodule : flash_cmd_props
bind flash_cmd flash_cmd_props #(.LARGE_DENSITY(LARGE_DENSITY)) u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .so_oe_o(so_oe_o), .rd_req_o(rd_req_o),
  .rd_addr_o(rd_addr_o), .erase_o(erase_o), .prog_o(prog_o), .prog_valid_o(prog_valid_o),
  .prog_ready_i(prog_ready_i), .protect_o(protect_o));

// File: verif/spi_host_model.sv
// spi host model driving select, clock and serial data
`timescale 1ns/100ps
module spi_host_model (
  input  wire logic clk_i,
  input  wire logic so_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  task automatic sel();
    @(negedge clk_i) cs_n_o = 1'b0;
    repeat (8) @(negedge clk_i);
  endtask : sel
  // select rises with sck low; si flips so stale data is never seen
  task automatic des();
    cs_n_o = 1'b1;
    si_o = ~si_o;
    repeat (24) @(negedge clk_i);
  endtask : des
  // 160 ns per bit keeps every opcode below its clock limit
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si_o = tx[i];
      repeat (8) @(negedge clk_i);
      rx[i] = so_i;
      sck_o = 1'b1;
      repeat (8) @(negedge clk_i);
      sck_o = 1'b0;
    end
  endtask : xfer
endmodule : spi_host_model

// File: verif/flash_cmd_tb.sv
// self-checking bench for the flash command interpreter
`timescale 1ns/100ps
`include "flash_cmd_defs.svh"
module flash_cmd_tb;
  logic                      clk_i, rst_n_i, sck_i, cs_n_i, si_i, so_o, so_oe_o, rd_req_o;
  logic                      prog_valid_o, prog_ready_i, array_busy_i;
  logic [`ADDR_W-1:0]        rd_addr_o;
  logic [7:0]                rd_data_i, rx;
  logic [1:0]                protect_o;
  flash_cmd_pkg::prog_word_t prog_o, pq[$];
  flash_cmd_pkg::erase_req_t erase_o, eq[$];
  int                        bad_count, num_checks;
  flash_cmd u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
    .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o),
    .rd_data_i(rd_data_i), .array_busy_i(array_busy_i), .prog_o(prog_o),
    .prog_valid_o(prog_valid_o), .prog_ready_i(prog_ready_i), .erase_o(erase_o),
    .protect_o(protect_o));
  spi_host_model u_host (.clk_i(clk_i), .so_i(so_o), .sck_o(sck_i), .cs_n_o(cs_n_i),
    .si_o(si_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] mem(input logic [18:0] a);
    return a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]} ^ 8'hA5;
  endfunction : mem
  always @(negedge clk_i) if (rd_req_o) rd_data_i <= mem(rd_addr_o);
  always @(posedge clk_i) begin
    if (prog_valid_o && prog_ready_i) pq.push_back(prog_o);
    if (erase_o.valid) eq.push_back(erase_o);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [39:0] w, input int nb);
    for (int i = 0; i < nb; i++) u_host.xfer(w[39-8*i -: 8], 8, rx);
  endtask : send
  task automatic op(input logic [39:0] w, input int nb);
    u_host.sel();
    send(w, nb);
    u_host.des();
  endtask : op
  task automatic get(input logic [7:0] exp);
    u_host.xfer(8'h00, 8, rx);
    chk(rx, exp);
  endtask : get
  task automatic stat(input logic [7:0] exp);
    u_host.sel();
    send({8'h05, 32'h0}, 1);
    get(exp);
    get(exp);
    u_host.des();
  endtask : stat
  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_latch();
    u_host.sel();
    u_host.xfer(8'h06, 8, rx);
    u_host.xfer(8'h00, 3, rx);
    u_host.des();
    stat(8'h0C);
    op({8'h06, 32'h0}, 1);
    stat(8'h0E);
    @(negedge clk_i) array_busy_i = 1'b1;
    stat(8'h0F);
    @(negedge clk_i) array_busy_i = 1'b0;
    op({8'h04, 32'h0}, 1);
    stat(8'h0C);
  endtask : t_latch
  task automatic t_read();
    u_host.sel();
    send({8'h03, 24'hF7FFFE, 8'h0}, 4);
    for (int i = 0; i < 4; i++) get(mem(19'(19'h7FFFE + i)));
    u_host.des();
    u_host.sel();
    send({8'h0B, 24'hA12345, 8'hFF}, 5);
    get(mem(19'h12345));
    get(mem(19'h12346));
    u_host.des();
  endtask : t_read
  task automatic t_id();
    for (int k = 0; k < 2; k++) begin
      u_host.sel();
      send({k ? 8'hAB : 8'h90, 23'h0, k[0], 8'h0}, 4);
      for (int j = 0; j < 3; j++) get(((j + k) % 2) ? `PART_CODE_LARGE : `MAKER_CODE);
      u_host.des();
    end
  endtask : t_id
  task automatic t_erase();
    op({8'h20, 24'hFFFFFF, 8'h0}, 4);
    op({8'h06, 32'h0}, 1);
    op({8'h20, 24'hFFFFFF, 8'h0}, 4);
    op({8'h06, 32'h0}, 1);
    op({8'h52, 24'hFFFFFF, 8'h0}, 4);
    op({8'h06, 32'h0}, 1);
    op({8'h60, 32'h0}, 1);
    chk(eq.size(), 2);
    chk(32'(eq[0]), {1'b1, 2'h0, 19'h7F000});
    chk(32'(eq[1]), {1'b1, 2'h1, 19'h78000});
    op({8'h01, 8'h00, 24'h0}, 2);
    chk(protect_o, 2'h3);
    op({8'h50, 32'h0}, 1);
    op({8'h01, 8'h00, 24'h0}, 2);
    chk(protect_o, 2'h0);
    op({8'h06, 32'h0}, 1);
    op({8'h60, 32'h0}, 1);
    chk(eq.size(), 3);
  endtask : t_erase
  task automatic t_prog();
    @(negedge clk_i) prog_ready_i = 1'b0;
    op({8'h06, 32'h0}, 1);
    op({8'hAF, 24'h07FFF0, 8'h11}, 5);
    for (int i = 1; i < 10; i++) op({8'hAF, 8'(8'h11 + i), 24'h0}, 2);
    stat(8'h43);
    chk(prog_valid_o, 1'b1);
    @(negedge clk_i) prog_ready_i = 1'b1;
    repeat (40) @(negedge clk_i);
    op({8'h04, 32'h0}, 1);
    stat(8'h00);
    chk(pq.size(), 10);
    for (int i = 0; i < 10; i++) chk(pq[i], {19'(19'h7FFF0 + i), 8'(8'h11 + i)});
  endtask : t_prog
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_i = 1'b0;
    array_busy_i = 1'b0;
    prog_ready_i = 1'b1;
    rd_data_i = 8'h00;
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (8) @(negedge clk_i);
    t_latch();
    t_read();
    t_id();
    t_erase();
    t_prog();
    print_verdict();
  end
  // whole run needs about 14k cycles
  initial begin
    repeat (90000) @(posedge clk_i);
    bad_count++;
    print_verdict();
  end
endmodule : flash_cmd_tb
